// >>> logic/scp_regs.vh
// Constants of the sensor channel configuration parameter set.
// Assumes the includer works in an 8-bit parameter space with a 17-bit converter.
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

// Parameter offsets, reached only through the parameter commands.
`define SCP_OFS_PENDING_ADDR   8'h00
`define SCP_OFS_CHANNEL_LIST   8'h01
`define SCP_OFS_EMIT_ONE_TWO   8'h02
`define SCP_OFS_EMIT_THREE     8'h03
`define SCP_OFS_RESERVED_ZERO  8'h04
`define SCP_OFS_PROX_ALIGN     8'h05
`define SCP_OFS_AMB_ALIGN      8'h06

// Reset values.
`define SCP_RST_PENDING_ADDR   8'h00
`define SCP_RST_CHANNEL_LIST   8'h00
`define SCP_RST_EMIT_ONE_TWO   8'h00
`define SCP_RST_EMIT_THREE     8'h04
`define SCP_RST_PROX_ALIGN     8'h00
`define SCP_RST_AMB_ALIGN      8'h00

// Writable bit masks; every other bit is reserved and held at zero.
`define SCP_MASK_PENDING_ADDR  8'hFF
`define SCP_MASK_CHANNEL_LIST  8'hF7
`define SCP_MASK_EMIT_ONE_TWO  8'h77
`define SCP_MASK_EMIT_THREE    8'h07
`define SCP_MASK_PROX_ALIGN    8'h70
`define SCP_MASK_AMB_ALIGN     8'h30

// Channel list bit positions.
`define SCP_BIT_UV_EN          7
`define SCP_BIT_AUX_EN         6
`define SCP_BIT_AMB_IR_EN      5
`define SCP_BIT_AMB_VIS_EN     4
`define SCP_BIT_PROX3_EN       2
`define SCP_BIT_PROX2_EN       1
`define SCP_BIT_PROX1_EN       0

// Emitter field positions.
`define SCP_EMIT1_LSB          0
`define SCP_EMIT2_LSB          4
`define SCP_EMIT3_LSB          0

// Alignment bit positions.
`define SCP_BIT_PROX3_LOW      6
`define SCP_BIT_PROX2_LOW      5
`define SCP_BIT_PROX1_LOW      4
`define SCP_BIT_AMB_VIS_LOW    5
`define SCP_BIT_AMB_IR_LOW     4

// Command codes.
`define SCP_CMD_NONE           2'h0
`define SCP_CMD_PARAM_WRITE    2'h1
`define SCP_CMD_PARAM_READ     2'h2
`define SCP_CMD_BUS_ADDRESS    2'h3

// Measurement channel codes.
`define SCP_CH_PROX1           3'h0
`define SCP_CH_PROX2           3'h1
`define SCP_CH_PROX3           3'h2
`define SCP_CH_AMB_VIS         3'h3
`define SCP_CH_AMB_IR          3'h4
`define SCP_CH_AUX             3'h5
`define SCP_CH_UV              3'h6

// Result slots; the auxiliary slot is shared by the UV index and the aux channel.
`define SCP_SLOT_PROX1         3'h0
`define SCP_SLOT_PROX2         3'h1
`define SCP_SLOT_PROX3         3'h2
`define SCP_SLOT_AMB_VIS       3'h3
`define SCP_SLOT_AMB_IR        3'h4
`define SCP_SLOT_AUX           3'h5
`define SCP_RST_RESULT         16'h0000

`endif

// >>> logic/scp_result_align.v
// Picks which 16 of the 17 converter bits are reported for one measurement.
// Assumes the raw conversion is stable while the caller samples the output.
`timescale 1ns/1ps

module scp_result_align (
    lowBitsSelect,
    convRaw,
    alignedResult
);
    input  wire        lowBitsSelect;
    input  wire [16:0] convRaw;
    output reg  [15:0] alignedResult;

    // Set selects the low sixteen bits, clear the upper sixteen.
    always @* begin
        if (lowBitsSelect) begin
            alignedResult = convRaw[15:0];
        end else begin
            alignedResult = convRaw[16:1];
        end
    end
endmodule // scp_result_align

// >>> logic/scp_result_regs.v
// Holds the high and low result byte pairs of the six result slots.
// Assumes at most one slot write per clock, issued by the parameter bank.
`timescale 1ns/1ps
`include "scp_regs.vh"

module scp_result_regs (
    ref_clk,
    rst_n,
    writeEn,
    writeSlot,
    writeData,
    prox1Result,
    prox2Result,
    prox3Result,
    ambVisResult,
    ambIrResult,
    auxResult
);
    input  wire        ref_clk;
    input  wire        rst_n;
    input  wire        writeEn;
    input  wire [2:0]  writeSlot;
    input  wire [15:0] writeData;
    output reg  [15:0] prox1Result;
    output reg  [15:0] prox2Result;
    output reg  [15:0] prox3Result;
    output reg  [15:0] ambVisResult;
    output reg  [15:0] ambIrResult;
    output reg  [15:0] auxResult;

    // Each slot keeps its last result until the same slot is written again.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prox1Result  <= `SCP_RST_RESULT;
            prox2Result  <= `SCP_RST_RESULT;
            prox3Result  <= `SCP_RST_RESULT;
            ambVisResult <= `SCP_RST_RESULT;
            ambIrResult  <= `SCP_RST_RESULT;
            auxResult    <= `SCP_RST_RESULT;
        end else if (writeEn) begin
            case (writeSlot)
                `SCP_SLOT_PROX1: begin
                    prox1Result <= writeData;
                end
                `SCP_SLOT_PROX2: begin
                    prox2Result <= writeData;
                end
                `SCP_SLOT_PROX3: begin
                    prox3Result <= writeData;
                end
                `SCP_SLOT_AMB_VIS: begin
                    ambVisResult <= writeData;
                end
                `SCP_SLOT_AMB_IR: begin
                    ambIrResult <= writeData;
                end
                `SCP_SLOT_AUX: begin
                    auxResult <= writeData;
                end
                default: begin
                    auxResult <= auxResult;
                end
            endcase
        end
    end
endmodule // scp_result_regs

// >>> logic/scp_param_bank.v
// Configuration parameter set of the light and proximity sensor channel engine.
// Assumes the command engine issues one-cycle parameter commands on ref_clk,
// and the converter reports finished 17-bit conversions tagged by channel.
//
// How it works
// - Parameters have no direct address and are reached only through write and read commands.
// - An 8-bit pending bus address becomes the live address on a bus address command.
// - Channel list bit 7 enables the UV index, whose result lands in the auxiliary result pair.
// - Channel list bit 6 enables the auxiliary channel, sharing the same auxiliary result pair.
// - Bits 5 and 4 enable the ambient infrared and visible channels with separate result pairs.
// - Bits 2, 1 and 0 enable proximity channels 3, 2 and 1, and bit 3 is reserved.
// - Channels 1 and 2 pick emitters with fields at bits 2:0 and 6:4, one bit per LED driver.
// - Channel 3 picks emitters with bits 2:0 of its own parameter, resetting to the third LED.
// - Proximity alignment bits 6, 5, 4 pick low or upper 16 result bits of channels 3, 2, 1.
// - Ambient alignment bit 5 acts on the visible result and bit 4 on the infrared result.
`timescale 1ns/1ps
`include "scp_regs.vh"

module scp_param_bank (
    ref_clk,
    rst_n,
    cmdValid,
    cmdCode,
    cmdOffset,
    cmdWriteData,
    cmdDone,
    cmdError,
    paramReadData,
    activeBusAddress,
    channelListEmpty,
    measActive,
    measChannel,
    emitterDrive,
    convValid,
    convChannel,
    convRaw,
    prox1Result,
    prox2Result,
    prox3Result,
    ambVisResult,
    ambIrResult,
    auxResult
);
    // Bus address answered until the first bus address command.
    parameter [7:0] BOOT_BUS_ADDRESS = 8'h00;

    input  wire        ref_clk;
    input  wire        rst_n;
    input  wire        cmdValid;
    input  wire [1:0]  cmdCode;
    input  wire [7:0]  cmdOffset;
    input  wire [7:0]  cmdWriteData;
    output reg         cmdDone;
    output reg         cmdError;
    output reg  [7:0]  paramReadData;
    output reg  [7:0]  activeBusAddress;
    output wire        channelListEmpty;
    input  wire        measActive;
    input  wire [2:0]  measChannel;
    output reg  [2:0]  emitterDrive;
    input  wire        convValid;
    input  wire [2:0]  convChannel;
    input  wire [16:0] convRaw;
    output wire [15:0] prox1Result;
    output wire [15:0] prox2Result;
    output wire [15:0] prox3Result;
    output wire [15:0] ambVisResult;
    output wire [15:0] ambIrResult;
    output wire [15:0] auxResult;

    // Parameter storage.
    reg  [7:0]  pendingAddr_reg;
    reg  [7:0]  channelList_reg;
    reg  [7:0]  emitOneTwo_reg;
    reg  [7:0]  emitThree_reg;
    reg  [7:0]  proxAlign_reg;
    reg  [7:0]  ambAlign_reg;

    // Command decode and read path.
    wire        paramWrite;
    wire        paramRead;
    wire        busAddrCmd;
    reg         offsetKnown;
    reg  [7:0]  readMux;

    // Conversion path.
    reg         convEnabled;
    reg         convLowSelect;
    reg  [2:0]  convSlot;
    wire [15:0] convAligned;
    wire        resultWrite;

    // Emitter selection for the running measurement.
    reg  [2:0]  emitterDrive_next;

    // Tells whether a given channel code is enabled in a channel list.
    function chanEnabled;
        input [7:0] list;
        input [2:0] chan;
        begin
            case (chan)
                `SCP_CH_PROX1:   chanEnabled = list[`SCP_BIT_PROX1_EN];
                `SCP_CH_PROX2:   chanEnabled = list[`SCP_BIT_PROX2_EN];
                `SCP_CH_PROX3:   chanEnabled = list[`SCP_BIT_PROX3_EN];
                `SCP_CH_AMB_VIS: chanEnabled = list[`SCP_BIT_AMB_VIS_EN];
                `SCP_CH_AMB_IR:  chanEnabled = list[`SCP_BIT_AMB_IR_EN];
                `SCP_CH_AUX:     chanEnabled = list[`SCP_BIT_AUX_EN];
                `SCP_CH_UV:      chanEnabled = list[`SCP_BIT_UV_EN];
                default:         chanEnabled = 1'b0;
            endcase
        end
    endfunction

    // Stores a written value with its reserved bits forced low.
    function [7:0] keepWritable;
        input [7:0] value;
        input [7:0] mask;
        begin
            keepWritable = value & mask;
        end
    endfunction

    // Strobes of the three parameter commands.
    // command access only
    assign paramWrite = cmdValid && (cmdCode == `SCP_CMD_PARAM_WRITE);
    assign paramRead  = cmdValid && (cmdCode == `SCP_CMD_PARAM_READ);
    assign busAddrCmd = cmdValid && (cmdCode == `SCP_CMD_BUS_ADDRESS);

    // Informs the command engine that no channel is enabled yet.
    // empty list flagged
    assign channelListEmpty = (channelList_reg == 8'h00);

    // Read multiplexer; unknown offsets and the fixed zero slot read zero.
    always @* begin
        offsetKnown = 1'b1;
        readMux     = 8'h00;
        case (cmdOffset)
            `SCP_OFS_PENDING_ADDR: begin
                readMux = pendingAddr_reg;
            end
            `SCP_OFS_CHANNEL_LIST: begin
                readMux = channelList_reg;
            end
            `SCP_OFS_EMIT_ONE_TWO: begin
                readMux = emitOneTwo_reg;
            end
            `SCP_OFS_EMIT_THREE: begin
                readMux = emitThree_reg;
            end
            `SCP_OFS_RESERVED_ZERO: begin
                readMux = 8'h00;
            end
            `SCP_OFS_PROX_ALIGN: begin
                readMux = proxAlign_reg;
            end
            `SCP_OFS_AMB_ALIGN: begin
                readMux = ambAlign_reg;
            end
            default: begin
                offsetKnown = 1'b0;
            end
        endcase
    end

    // Parameter writes; a write to the fixed zero slot or an unknown offset has no effect.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pendingAddr_reg <= `SCP_RST_PENDING_ADDR;
            channelList_reg <= `SCP_RST_CHANNEL_LIST;
            emitOneTwo_reg  <= `SCP_RST_EMIT_ONE_TWO;
            emitThree_reg   <= `SCP_RST_EMIT_THREE;
            proxAlign_reg   <= `SCP_RST_PROX_ALIGN;
            ambAlign_reg    <= `SCP_RST_AMB_ALIGN;
        end else if (paramWrite) begin
            case (cmdOffset)
                `SCP_OFS_PENDING_ADDR: begin
                    pendingAddr_reg <= keepWritable(cmdWriteData, `SCP_MASK_PENDING_ADDR);
                end
                `SCP_OFS_CHANNEL_LIST: begin
                    channelList_reg <= keepWritable(cmdWriteData, `SCP_MASK_CHANNEL_LIST);
                end
                `SCP_OFS_EMIT_ONE_TWO: begin
                    emitOneTwo_reg <= keepWritable(cmdWriteData, `SCP_MASK_EMIT_ONE_TWO);
                end
                `SCP_OFS_EMIT_THREE: begin
                    emitThree_reg <= keepWritable(cmdWriteData, `SCP_MASK_EMIT_THREE);
                end
                `SCP_OFS_PROX_ALIGN: begin
                    proxAlign_reg <= keepWritable(cmdWriteData, `SCP_MASK_PROX_ALIGN);
                end
                `SCP_OFS_AMB_ALIGN: begin
                    ambAlign_reg <= keepWritable(cmdWriteData, `SCP_MASK_AMB_ALIGN);
                end
                default: begin
                    ambAlign_reg <= ambAlign_reg;
                end
            endcase
        end
    end

    // Command answer: done pulse, error pulse on a write or read to an unknown offset, and read data.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdDone       <= 1'b0;
            cmdError      <= 1'b0;
            paramReadData <= 8'h00;
        end else begin
            cmdDone  <= paramWrite || paramRead || busAddrCmd;
            cmdError <= (paramWrite || paramRead) && !offsetKnown;
            if (paramRead) begin
                paramReadData <= readMux;
            end
        end
    end

    // Live bus address; it only moves on a bus address command.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeBusAddress <= BOOT_BUS_ADDRESS;
        end else if (busAddrCmd) begin
            activeBusAddress <= pendingAddr_reg;
        end
    end

    // Emitter drivers for the proximity measurement now running.
    always @* begin
        emitterDrive_next = 3'b000;
        if (measActive && chanEnabled(channelList_reg, measChannel)) begin
            case (measChannel)
                `SCP_CH_PROX1: begin
                    emitterDrive_next = emitOneTwo_reg[`SCP_EMIT1_LSB +: 3];
                end
                `SCP_CH_PROX2: begin
                    emitterDrive_next = emitOneTwo_reg[`SCP_EMIT2_LSB +: 3];
                end
                `SCP_CH_PROX3: begin
                    emitterDrive_next = emitThree_reg[`SCP_EMIT3_LSB +: 3];
                end
                default: begin
                    emitterDrive_next = 3'b000;
                end
            endcase
        end
    end

    // Registers the emitter enables so the drivers see a clean level.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            emitterDrive <= 3'b000;
        end else begin
            emitterDrive <= emitterDrive_next;
        end
    end

    // Maps a finished conversion to its result slot and its alignment choice.
    always @* begin
        convEnabled   = chanEnabled(channelList_reg, convChannel);
        convLowSelect = 1'b0;
        convSlot      = `SCP_SLOT_AUX;
        case (convChannel)
            `SCP_CH_PROX1: begin
                convSlot      = `SCP_SLOT_PROX1;
                convLowSelect = proxAlign_reg[`SCP_BIT_PROX1_LOW];
            end
            `SCP_CH_PROX2: begin
                convSlot      = `SCP_SLOT_PROX2;
                convLowSelect = proxAlign_reg[`SCP_BIT_PROX2_LOW];
            end
            `SCP_CH_PROX3: begin
                convSlot      = `SCP_SLOT_PROX3;
                convLowSelect = proxAlign_reg[`SCP_BIT_PROX3_LOW];
            end
            `SCP_CH_AMB_VIS: begin
                convSlot      = `SCP_SLOT_AMB_VIS;
                convLowSelect = ambAlign_reg[`SCP_BIT_AMB_VIS_LOW];
            end
            `SCP_CH_AMB_IR: begin
                convSlot      = `SCP_SLOT_AMB_IR;
                convLowSelect = ambAlign_reg[`SCP_BIT_AMB_IR_LOW];
            end
            `SCP_CH_AUX: begin
                convSlot = `SCP_SLOT_AUX;
            end
            `SCP_CH_UV: begin
                convSlot = `SCP_SLOT_AUX;
            end
            default: begin
                convEnabled = 1'b0;
            end
        endcase
    end

    // Results of disabled channels are dropped.
    // enabled channels only
    assign resultWrite = convValid && convEnabled;

    // Alignment of the conversion being stored.
    scp_result_align uAlign (
        .lowBitsSelect (convLowSelect),
        .convRaw       (convRaw),
        .alignedResult (convAligned)
    );

    // Result register pairs.
    scp_result_regs uResults (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .writeEn      (resultWrite),
        .writeSlot    (convSlot),
        .writeData    (convAligned),
        .prox1Result  (prox1Result),
        .prox2Result  (prox2Result),
        .prox3Result  (prox3Result),
        .ambVisResult (ambVisResult),
        .ambIrResult  (ambIrResult),
        .auxResult    (auxResult)
    );

endmodule // scp_param_bank

// >>> bench/scp_param_bank_assertions.sv
// Checker of the parameter bank command, emitter and result ports.
// Assumes it is bound to the bank and sees its ports only, on one clock.
`timescale 1ns/1ps

module scp_param_bank_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        cmdValid,
    input wire logic [1:0]  cmdCode,
    input wire logic [7:0]  cmdOffset,
    input wire logic [7:0]  cmdWriteData,
    input wire logic        cmdDone,
    input wire logic        cmdError,
    input wire logic [7:0]  paramReadData,
    input wire logic [7:0]  activeBusAddress,
    input wire logic        channelListEmpty,
    input wire logic        measActive,
    input wire logic [2:0]  measChannel,
    input wire logic [2:0]  emitterDrive,
    input wire logic        convValid,
    input wire logic [2:0]  convChannel,
    input wire logic [15:0] auxResult
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Commands are answered and errors raised exactly one cycle later.
    wire isCmd    = cmdValid && (cmdCode != 2'h0);
    wire isAccess = cmdValid && (cmdCode == 2'h1 || cmdCode == 2'h2);
    wire listWr   = cmdValid && cmdCode == 2'h1 && cmdOffset == 8'h01;

    chk_done_one_cycle: assert property (isCmd |=> cmdDone)
        else $error("command not answered after one cycle");
    chk_no_stray_done: assert property (!isCmd |=> !cmdDone)
        else $error("answer without a command");
    chk_error_unmapped: assert property (isAccess && cmdOffset > 8'h06
        |=> cmdError && cmdDone)
        else $error("unmapped offset not flagged");
    chk_error_mapped: assert property (isCmd && !(isAccess && cmdOffset > 8'h06)
        |=> !cmdError)
        else $error("error on a mapped access");
    chk_addr_switch_cause: assert property (!$stable(activeBusAddress) |->
        $past(cmdValid && cmdCode == 2'h3))
        else $error("live address changed without an address command");
    chk_list_nonempty: assert property (listWr && (cmdWriteData & 8'hF7) != 8'h00
        |=> !channelListEmpty)
        else $error("list reads empty after a non-zero write");
    chk_list_empty: assert property (listWr && (cmdWriteData & 8'hF7) == 8'h00
        |=> channelListEmpty)
        else $error("reserved list bit kept");
    chk_emit_idle: assert property (!measActive |=> emitterDrive == 3'h0)
        else $error("emitters driven with no measurement");
    chk_emit_nonprox: assert property (measActive && measChannel > 3'h2
        |=> emitterDrive == 3'h0)
        else $error("emitters driven for a non-proximity channel");
    chk_reserved_read: assert property (cmdValid && cmdCode == 2'h2 && cmdOffset == 8'h04
        |=> paramReadData == 8'h00)
        else $error("reserved offset read non-zero");
    chk_aux_hold: assert property (!(convValid &&
        (convChannel == 3'h5 || convChannel == 3'h6)) |=> $stable(auxResult))
        else $error("auxiliary result changed without its conversion");

    // Main scenarios reached.
    cov_bus_cmd: cover property (cmdValid && cmdCode == 2'h3 ##1 cmdDone);
    cov_error: cover property (cmdError);
    cov_emit: cover property (emitterDrive != 3'h0);
endmodule // scp_param_bank_checker

bind scp_param_bank scp_param_bank_checker chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdOffset(cmdOffset), .cmdWriteData(cmdWriteData), .cmdDone(cmdDone),
    .cmdError(cmdError), .paramReadData(paramReadData), .activeBusAddress(activeBusAddress),
    .channelListEmpty(channelListEmpty), .measActive(measActive), .measChannel(measChannel),
    .emitterDrive(emitterDrive), .convValid(convValid), .convChannel(convChannel),
    .auxResult(auxResult)
);

// >>> bench/scp_host_model.sv
// Host controller model that issues parameter and address commands.
// Assumes the bank answers every command at the taking edge, one cycle after it is driven.
`timescale 1ns/1ps

module scp_host_model #(parameter int LED_DRIVERS = 3) (
    input wire logic  ref_clk,
    output logic      cmdValid,
    output logic [1:0] cmdCode,
    output logic [7:0] cmdOffset,
    output logic [7:0] cmdWriteData,
    input wire logic  cmdDone,
    input wire logic  cmdError,
    input wire logic [7:0] paramReadData
);
    // Idle command lines at time zero.
    initial begin
        cmdValid = 1'b0;
        cmdCode = 2'h0;
        cmdOffset = 8'h00;
        cmdWriteData = 8'h00;
    end

    task automatic doCmd(input logic [1:0] code, input logic [7:0] ofs, input logic [7:0] data,
                         output logic [7:0] rd, output logic err, output logic done);
        logic [7:0] keep;
        keep = 8'hFF;
        if (LED_DRIVERS < 3) keep = 8'hBB;
        if (LED_DRIVERS < 2) keep = 8'h99;
        if (code == 2'h1 && (ofs == 8'h02 || ofs == 8'h03)) data = data & keep;
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdOffset <= ofs;
        cmdWriteData <= data;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        cmdCode <= 2'h0;
        cmdOffset <= ~ofs;       // Released lines do not keep the last value.
        cmdWriteData <= ~data;
        #1;
        rd = paramReadData;
        err = cmdError;
        done = cmdDone;
    endtask
endmodule // scp_host_model

// >>> bench/sensor_channel_config_params_tb.sv
// Self-checking bench of the sensor channel parameter bank.
// Assumes the host model drives commands and this module drives converter inputs.
`timescale 1ns/1ps
`include "scp_regs.vh"
`define CHK_EQ(name, exp, got) begin testsRun++; if ((got) !== (exp)) begin numErrors++; \
    $display("MISMATCH %s expected %h seen %h", name, exp, got); end end

module sensor_channel_config_params_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic measActive = 1'b0;
    logic [2:0] measChannel = 3'h0;
    logic convValid = 1'b0;
    logic [2:0] convChannel = 3'h0;
    logic [16:0] convRaw = 17'h0_0000;
    logic cmdValid, cmdDone, cmdError, channelListEmpty;
    logic [1:0] cmdCode;
    logic [7:0] cmdOffset, cmdWriteData, paramReadData, activeBusAddress;
    logic [2:0] emitterDrive;
    logic [15:0] prox1Result, prox2Result, prox3Result, ambVisResult, ambIrResult, auxResult;
    int numErrors = 0;
    int testsRun = 0;
    logic [7:0] rstVal [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    logic [7:0] maskVal [7] = '{8'hFF, 8'hF7, 8'h77, 8'h07, 8'h00, 8'h70, 8'h30};
    logic [2:0] expEmit [7] = '{3'h5, 3'h3, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0};
    logic lowSel [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    // Clock at 20 MHz.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    scp_host_model host (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdOffset(cmdOffset), .cmdWriteData(cmdWriteData), .cmdDone(cmdDone),
        .cmdError(cmdError), .paramReadData(paramReadData));

    scp_param_bank uut (.ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdOffset(cmdOffset), .cmdWriteData(cmdWriteData),
        .cmdDone(cmdDone), .cmdError(cmdError), .paramReadData(paramReadData),
        .activeBusAddress(activeBusAddress), .channelListEmpty(channelListEmpty),
        .measActive(measActive), .measChannel(measChannel), .emitterDrive(emitterDrive),
        .convValid(convValid), .convChannel(convChannel), .convRaw(convRaw),
        .prox1Result(prox1Result), .prox2Result(prox2Result), .prox3Result(prox3Result),
        .ambVisResult(ambVisResult), .ambIrResult(ambIrResult), .auxResult(auxResult));

    // Prints the counts and the verdict, then ends the run.
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Parameter access through the command path, checked for completion.
    task automatic access(input logic [1:0] code, input logic [7:0] ofs, input logic [7:0] data,
                          input logic expErr, input logic [7:0] expRd, input logic chkRd);
        logic [7:0] r;
        logic e;
        logic d;
        host.doCmd(code, ofs, data, r, e, d);
        `CHK_EQ("command done", 1'b1, d)
        `CHK_EQ("command error", expErr, e)
        if (chkRd) `CHK_EQ("parameter read", expRd, r)
    endtask

    // One measurement step; emitters are looked at one cycle later.
    task automatic measChk(input logic act, input logic [2:0] ch, input logic [2:0] exp);
        @(posedge ref_clk);
        measActive <= act;
        measChannel <= ch;
        @(posedge ref_clk);
        #1;
        `CHK_EQ("emitter drive", exp, emitterDrive)
    endtask

    // Result slot seen for a channel code.
    function automatic logic [15:0] resOf(input logic [2:0] ch);
        case (ch)
            3'h0: resOf = prox1Result;
            3'h1: resOf = prox2Result;
            3'h2: resOf = prox3Result;
            3'h3: resOf = ambVisResult;
            3'h4: resOf = ambIrResult;
            default: resOf = auxResult;
        endcase
    endfunction

    // One conversion pulse; the result slot is looked at one cycle later.
    task automatic convChk(input logic [2:0] ch, input logic [16:0] raw, input logic [15:0] exp);
        @(posedge ref_clk);
        convValid <= 1'b1;
        convChannel <= ch;
        convRaw <= raw;
        @(posedge ref_clk);
        convValid <= 1'b0;
        convRaw <= ~raw;
        #1;
        `CHK_EQ("result slot", exp, resOf(ch))
    endtask

    // Watchdog against a hung command or handshake.
    initial begin
        #(50 * 5000);
        numErrors++;
        tallyAndFinish();
    end

    // Main test sequence.
    initial begin
        logic [16:0] raw;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) access(2'h2, i[7:0], 8'h00, 1'b0, rstVal[i], 1'b1);
        `CHK_EQ("list empty at reset", 1'b1, channelListEmpty)
        for (int i = 0; i < 7; i++) begin
            access(2'h1, i[7:0], 8'hFF, 1'b0, 8'h00, 1'b0);
            access(2'h2, i[7:0], 8'h00, 1'b0, maskVal[i], 1'b1);
        end
        access(2'h1, 8'h07, 8'hFF, 1'b1, 8'h00, 1'b0);
        access(2'h2, 8'hFF, 8'h00, 1'b1, 8'h00, 1'b1);
        access(2'h1, 8'h01, 8'h08, 1'b0, 8'h00, 1'b0);
        `CHK_EQ("reserved list bit", 1'b1, channelListEmpty)
        `CHK_EQ("address before switch", 8'h00, activeBusAddress)
        access(2'h1, 8'h00, 8'h5A, 1'b0, 8'h00, 1'b0);
        `CHK_EQ("address still old", 8'h00, activeBusAddress)
        access(2'h3, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
        `CHK_EQ("address switched", 8'h5A, activeBusAddress)
        access(2'h1, 8'h01, 8'h07, 1'b0, 8'h00, 1'b0);
        access(2'h1, 8'h02, 8'h35, 1'b0, 8'h00, 1'b0);
        access(2'h1, 8'h03, 8'h06, 1'b0, 8'h00, 1'b0);
        for (int c = 0; c < 7; c++) measChk(1'b1, c[2:0], expEmit[c]);
        measChk(1'b0, 3'h0, 3'h0);
        access(2'h1, 8'h01, 8'h01, 1'b0, 8'h00, 1'b0);
        measChk(1'b1, 3'h1, 3'h0);
        measChk(1'b1, 3'h0, 3'h5);
        measChk(1'b0, 3'h0, 3'h0);
        access(2'h1, 8'h01, 8'hF7, 1'b0, 8'h00, 1'b0);
        access(2'h1, 8'h05, 8'h50, 1'b0, 8'h00, 1'b0);
        access(2'h1, 8'h06, 8'h20, 1'b0, 8'h00, 1'b0);
        for (int c = 0; c < 7; c++) begin
            raw = 17'h1_2340 + c;
            convChk(c[2:0], raw, lowSel[c] ? raw[15:0] : raw[16:1]);
        end
        access(2'h1, 8'h01, 8'h01, 1'b0, 8'h00, 1'b0);
        convChk(3'h6, 17'h0_0FFF, raw[16:1]);
        convChk(3'h4, 17'h0_0FFF, 16'h91A2);
        convChk(3'h0, 17'h1_FFFE, 16'hFFFE);
        tallyAndFinish();
    end
endmodule // sensor_channel_config_params_tb
